// >>> pkg/term_clock_pkg.sv
// Constants and types for the termination decode and clock-mode control.
// Contract
// [RL1] Termination enables decode only from control bits.
// [RL2] Decode transceiver, termsel, operating_mode_field, pulldown requests.
// [RL3] Undefined combos and operating_mode_field 01b: all off.
// [RL4] Positive pull-up for FS and chirp peripheral.
// [RL5] Negative pull-up only for low-speed peripheral.
// [RL6] Pull-downs follow their request bits.
// [RL7] HS termination: select 00b, termsel 0b.
// [RL8] Power-up row enables both pull-downs only.
// [RL9] OTG chirp: pos pull-up, neg pull-down.
// [RL10] OTG FS/suspend/resume: pull-up plus neg pull-down.
// [RL11] Test J/K: HS termination, optional neg pull-down.
// [RL12] Two clock modes: input or generated.
// [RL13] Sample clock pin at start-up for mode.
// [RL14] Link drives clock, ties clock pin high.
// [RL15] Release direction after lock; link waits.
// [RL16] Output mode: clock after lock, then release.
// [RL17] Link straps reference frequency select pins.
// [RL18] Host link sets automatic resume bit.
// [RL19] No reference-to-interface phase requirement.
// [RL20] Transmit path encodes, stuffs, serializes data.
// [RL21] HS receive squelch blocks noise as data.
// [RL22] Boost field raises HS transmit amplitude.
package term_clock_pkg;

  // ---------------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] XCVR_HS = 2'h0;
  localparam logic [1:0] XCVR_FS = 2'h1;
  localparam logic [1:0] XCVR_LS = 2'h2;
  localparam logic [1:0] XCVR_FS4LS = 2'h3;
  localparam logic [1:0] OPERATING_MODE_FIELD_NORMAL = 2'h0;
  localparam logic [1:0] OPERATING_MODE_FIELD_NONDRIVE = 2'h1;
  localparam logic [1:0] OPERATING_MODE_FIELD_NOSTUFF = 2'h2;

  // ---------------------------------------------------------------------
  // Bit positions in the termination enable vector
  // ---------------------------------------------------------------------
  localparam int TERM_PU_POS = 4;
  localparam int TERM_PU_NEG = 3;
  localparam int TERM_PD_POS = 2;
  localparam int TERM_PD_NEG = 1;
  localparam int TERM_HS = 0;
  localparam logic [4:0] TERM_ALL_OFF = 5'h00;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYCLES =
    (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BOOST_W = 3;
  localparam logic [2:0] BOOST_RESET = 3'h0;

  // Start-up sequencer states.
  typedef enum logic [3:0] {
    ST_STRAP = 4'h1,
    ST_LOCK  = 4'h2,
    ST_CLKON = 4'h4,
    ST_RUN   = 4'h8
  } startup_state_t;

endpackage : term_clock_pkg

// >>> verilog/term_decode.sv
// Combinational decode of the termination resistor enables.
`timescale 1ns/100ps
module term_decode
  import term_clock_pkg::*;
(
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_select,
  input wire logic [1:0] operating_mode_field,
  input wire logic pos_line_pulldown_request,
  input wire logic neg_line_pulldown_request,
  output logic [4:0] term_enables
);

  // ---------------------------------------------------------------------
  // Row matching
  // ---------------------------------------------------------------------

  // Row flags, one per signalling row group.
  logic host_pd;
  logic periph_pd;
  logic otg_pd;
  logic op_nrm;
  logic op_chp;
  logic op_any;
  logic [1:0] xs;
  logic ts;

  // Pull-down request pairs that are legal.
  assign host_pd = pos_line_pulldown_request & neg_line_pulldown_request;
  assign periph_pd = ~pos_line_pulldown_request &
    ~neg_line_pulldown_request;
  assign otg_pd = ~pos_line_pulldown_request & neg_line_pulldown_request;
  assign op_nrm = (operating_mode_field == OPERATING_MODE_FIELD_NORMAL);
  assign op_chp = (operating_mode_field == OPERATING_MODE_FIELD_NOSTUFF);
  assign op_any = op_nrm | op_chp;
  assign xs = transceiver_speed_select;
  assign ts = termination_select;

  // Walk the signalling rows; any unmatched setting stays all off.
  always_comb begin
    term_enables = TERM_ALL_OFF; // RL3
    if (operating_mode_field == OPERATING_MODE_FIELD_NONDRIVE) begin
      term_enables = TERM_ALL_OFF; // RL3
    end else if (host_pd) begin
      // Host rows and the power-up row: both pull-downs.
      if (xs == XCVR_HS && !ts && op_any) begin
        term_enables = 5'h07; // RL7
      end else if (xs == XCVR_FS && !ts && op_nrm) begin
        term_enables = 5'h06; // RL8
      end else if ((xs == XCVR_FS || xs == XCVR_FS4LS) && ts && op_nrm) begin
        term_enables = 5'h06; // RL6
      end else if ((xs == XCVR_FS || xs == XCVR_LS) && ts && op_any) begin
        term_enables = 5'h06; // RL6
      end
    end else if (periph_pd || otg_pd) begin
      // Peripheral rows; OTG variants add the negative pull-down.
      if (xs == XCVR_HS && ts && op_chp) begin
        term_enables[TERM_PU_POS] = 1'b1; // RL4 RL9
      end else if (xs == XCVR_HS && !ts && op_any) begin
        term_enables[TERM_HS] = 1'b1; // RL7 RL11
      end else if (xs == XCVR_FS && ts && op_any) begin
        term_enables[TERM_PU_POS] = 1'b1; // RL4 RL10
      end else if (xs == XCVR_LS && ts && op_any && periph_pd) begin
        term_enables[TERM_PU_NEG] = 1'b1; // RL5
      end
      if (term_enables != TERM_ALL_OFF) begin
        term_enables[TERM_PD_NEG] = neg_line_pulldown_request; // RL6
      end
    end
  end

endmodule : term_decode

// >>> verilog/term_clock_ctrl.sv
// Termination control and clock-mode start-up logic of the transceiver.
`timescale 1ns/100ps
module term_clock_ctrl
  import term_clock_pkg::*;
#(
  parameter int LOCK_CYCLES = 8000,
  parameter int CLK_DIV = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_select,
  input wire logic [1:0] operating_mode_field,
  input wire logic pos_line_pulldown_request,
  input wire logic neg_line_pulldown_request,
  input wire logic [BOOST_W-1:0] boost_field,
  input wire logic interface_clock_output_in,
  input wire logic pll_lock,
  input wire logic tx_bit,
  input wire logic tx_valid,
  input wire logic hs_rx_bit,
  input wire logic squelch,
  output logic pos_line_pullup_enable,
  output logic neg_line_pullup_enable,
  output logic pos_line_pulldown_enable,
  output logic neg_line_pulldown_enable,
  output logic highspeed_termination_enable,
  output logic output_clock_mode,
  output logic interface_clock_output,
  output logic interface_clock_output_oe_n,
  output logic dir,
  output logic [BOOST_W-1:0] tx_amplitude,
  output logic tx_line,
  output logic rx_data,
  output logic rx_data_valid
);

  // ---------------------------------------------------------------------
  // Termination decode
  // ---------------------------------------------------------------------

  logic [4:0] term_next;

  // Decode from the current control bits only.
  term_decode u_term_decode (
    .transceiver_speed_select(transceiver_speed_select), // RL2
    .termination_select(termination_select),
    .operating_mode_field(operating_mode_field),
    .pos_line_pulldown_request(pos_line_pulldown_request),
    .neg_line_pulldown_request(neg_line_pulldown_request),
    .term_enables(term_next)
  );

  // Register the enables so the pins come from flip-flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_line_pullup_enable <= 1'b0;
      neg_line_pullup_enable <= 1'b0;
      pos_line_pulldown_enable <= 1'b0;
      neg_line_pulldown_enable <= 1'b0;
      highspeed_termination_enable <= 1'b0;
    end else begin
      pos_line_pullup_enable <= term_next[TERM_PU_POS]; // RL1
      neg_line_pullup_enable <= term_next[TERM_PU_NEG];
      pos_line_pulldown_enable <= term_next[TERM_PD_POS];
      neg_line_pulldown_enable <= term_next[TERM_PD_NEG];
      highspeed_termination_enable <= term_next[TERM_HS];
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------

  logic strap_meta_reg;
  logic strap_sync_reg;
  logic lock_meta_reg;
  logic lock_sync_reg;

  // The strap level and lock flag come from outside and pass two stages.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= interface_clock_output_in;
      strap_sync_reg <= strap_meta_reg;
      lock_meta_reg <= pll_lock;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------------

  startup_state_t state_reg;
  logic [15:0] wait_reg;
  logic input_mode_reg;

  // Sample the strap, wait for lock, start the clock in output mode, then release dir.
  // Strap high means the link supplies the clock; it stays high there.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_STRAP;
      wait_reg <= 16'h0000;
      input_mode_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_STRAP: begin
          if (wait_reg == 16'(STRAP_SETTLE_CYCLES)) begin
            input_mode_reg <= strap_sync_reg; // RL13 RL14
            wait_reg <= 16'h0000;
            state_reg <= ST_LOCK;
          end else begin
            wait_reg <= wait_reg + 16'h0001;
          end
        end
        ST_LOCK: begin
          // Lock is taken from the loop or a minimum wait, whichever later.
          if (lock_sync_reg && wait_reg >= 16'(LOCK_CYCLES)) begin
            state_reg <= input_mode_reg ? ST_RUN : ST_CLKON; // RL12
          end else if (wait_reg < 16'(LOCK_CYCLES)) begin
            wait_reg <= wait_reg + 16'h0001;
          end
        end
        ST_CLKON: begin
          state_reg <= ST_RUN; // RL16
        end
        ST_RUN: begin
          if (!lock_sync_reg) begin
            wait_reg <= 16'h0000;
            state_reg <= ST_LOCK;
          end
        end
        default: begin
          state_reg <= ST_STRAP;
        end
      endcase
    end
  end

  // Direction is held until the loop is locked.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir <= 1'b1;
    end else begin
      dir <= (state_reg != ST_RUN); // RL15
    end
  end

  // ---------------------------------------------------------------------
  // Generated interface clock
  // ---------------------------------------------------------------------

  logic [7:0] div_reg;
  logic clk_run;

  // The divider runs free of any reference phase.
  assign clk_run = !input_mode_reg &&
    (state_reg == ST_CLKON || state_reg == ST_RUN);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      interface_clock_output <= 1'b0;
      interface_clock_output_oe_n <= 1'b1;
      output_clock_mode <= 1'b0;
    end else begin
      output_clock_mode <= !input_mode_reg && state_reg != ST_STRAP;
      interface_clock_output_oe_n <= !clk_run; // RL12
      if (!clk_run || div_reg == 8'(CLK_DIV / 2 - 1)) begin
        div_reg <= 8'h00;
        interface_clock_output <= clk_run & ~interface_clock_output; // RL19
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Transmit and receive data path
  // ---------------------------------------------------------------------

  logic [2:0] ones_reg;
  logic nrzi_reg;
  logic stuff;

  // Six ones in a row force a stuffed zero.
  assign stuff = (ones_reg == 3'h6);

  // NRZI encode with bit stuffing; a zero toggles the line.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ones_reg <= 3'h0;
      nrzi_reg <= 1'b1;
      tx_line <= 1'b1;
    end else begin
      if (!tx_valid) begin
        ones_reg <= 3'h0;
        nrzi_reg <= 1'b1;
      end else if (stuff || !tx_bit) begin
        ones_reg <= 3'h0; // RL20
        nrzi_reg <= ~nrzi_reg;
      end else begin
        ones_reg <= ones_reg + 3'h1;
      end
      tx_line <= nrzi_reg;
    end
  end

  logic rx_meta_reg;
  logic rx_sync_reg;
  logic squelch_meta_reg;
  logic squelch_sync_reg;

  // Receiver bit and squelch come from the analog side; two stages each.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
      squelch_meta_reg <= 1'b1;
      squelch_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= hs_rx_bit;
      rx_sync_reg <= rx_meta_reg;
      squelch_meta_reg <= squelch;
      squelch_sync_reg <= squelch_meta_reg;
    end
  end

  // Received bits pass only while squelch is clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_data <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data <= rx_sync_reg & ~squelch_sync_reg; // RL21
      rx_data_valid <= ~squelch_sync_reg;
    end
  end

  // Transmit amplitude follows the boost field.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_amplitude <= BOOST_RESET;
    end else begin
      tx_amplitude <= boost_field; // RL22
    end
  end

endmodule : term_clock_ctrl

// >>> bench/term_clock_chk.sv
// Concurrent checks on the termination and start-up ports.
`timescale 1ns/100ps
module term_clock_chk
  import term_clock_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_select,
  input wire logic [1:0] operating_mode_field,
  input wire logic pos_line_pulldown_request,
  input wire logic neg_line_pulldown_request,
  input wire logic pll_lock,
  input wire logic pos_line_pullup_enable,
  input wire logic neg_line_pullup_enable,
  input wire logic pos_line_pulldown_enable,
  input wire logic neg_line_pulldown_enable,
  input wire logic highspeed_termination_enable,
  input wire logic output_clock_mode,
  input wire logic interface_clock_output,
  input wire logic interface_clock_output_oe_n,
  input wire logic dir
);
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Control bits and resistor enables gathered for compact relations.
  wire logic [6:0] ctl = {transceiver_speed_select, termination_select,
    operating_mode_field, pos_line_pulldown_request,
    neg_line_pulldown_request};
  wire logic [4:0] en = {pos_line_pullup_enable, neg_line_pullup_enable,
    pos_line_pulldown_enable, neg_line_pulldown_enable,
    highspeed_termination_enable};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // One edge of the generated clock, or direction rising as it stops.
  sequence s_clk_edge;
    $changed(interface_clock_output) || $rose(dir);
  endsequence

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  AST_NONDRIVE_OFF: assert property (
    operating_mode_field == OPERATING_MODE_FIELD_NONDRIVE |=> en == TERM_ALL_OFF)
    else $error("termination on in non-drive mode");
  AST_DECODE_ONLY: assert property (
    $stable(ctl) && $past(rst_n) |=> $stable(en))
    else $error("enables moved with steady control bits");
  AST_PU_POS: assert property (
    pos_line_pullup_enable |->
      $past(termination_select && !pos_line_pulldown_request))
    else $error("positive pull-up outside peripheral rows");
  AST_PU_NEG: assert property (
    neg_line_pullup_enable |-> $past(transceiver_speed_select == XCVR_LS &&
      termination_select && !pos_line_pulldown_request &&
      !neg_line_pulldown_request))
    else $error("negative pull-up outside low-speed peripheral");
  AST_PD_POS: assert property (
    pos_line_pulldown_enable |-> $past(pos_line_pulldown_request))
    else $error("positive pull-down without request");
  AST_PD_NEG: assert property (
    neg_line_pulldown_enable |-> $past(neg_line_pulldown_request))
    else $error("negative pull-down without request");
  AST_HS_TERM: assert property (
    highspeed_termination_enable |-> $past(transceiver_speed_select ==
      XCVR_HS && !termination_select && !operating_mode_field[0]))
    else $error("high-speed termination in wrong row");
  AST_DIR_LOCK: assert property (
    $fell(dir) |-> $past(pll_lock))
    else $error("direction released without lock");
  AST_IN_MODE_QUIET: assert property (
    !output_clock_mode |-> interface_clock_output_oe_n)
    else $error("clock pin driven in input clock mode");
  AST_CLK_RUNS: assert property (
    !dir && output_clock_mode |->
      !interface_clock_output_oe_n ##0 (##[1:2] s_clk_edge))
    else $error("interface clock not running after release");
endmodule : term_clock_chk

bind term_clock_ctrl term_clock_chk u_term_clock_chk (.clk, .rst_n,
  .transceiver_speed_select, .termination_select, .operating_mode_field,
  .pos_line_pulldown_request, .neg_line_pulldown_request, .pll_lock,
  .pos_line_pullup_enable, .neg_line_pullup_enable,
  .pos_line_pulldown_enable, .neg_line_pulldown_enable,
  .highspeed_termination_enable, .output_clock_mode,
  .interface_clock_output, .interface_clock_output_oe_n, .dir);

// >>> bench/link_model.sv
// Link-side model that straps the clock pin of the transceiver.
`timescale 1ns/100ps
module link_model #(
  parameter logic [2:0] REF_STRAP_CODE = 3'h0,
  parameter logic HOST_ROLE = 1'h1
) (
  input wire logic input_clock_mode,
  input wire logic interface_clock_output,
  input wire logic interface_clock_output_oe_n,
  output logic pin_level,
  output logic [2:0] reference_frequency_strap,
  output logic automatic_resume_bit
);
  // Straps are all high in input mode, else the chosen reference code.
  assign reference_frequency_strap = input_clock_mode ? 3'h7
    : REF_STRAP_CODE;
  // A host link keeps automatic resume set in either clock mode.
  assign automatic_resume_bit = HOST_ROLE;
  // In input mode the link ties the pin high; in output mode a weak
  // pull-down keeps it low until the device drives its own clock.
  assign pin_level = !interface_clock_output_oe_n ? interface_clock_output
    : input_clock_mode;
endmodule : link_model

// >>> bench/testbench.sv
// Self-checking bench for the termination decode and clock start-up.
`timescale 1ns/100ps
module testbench;
  import term_clock_pkg::*;
  localparam int LOCK = 10;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] transceiver_speed_select = 2'h0;
  logic [1:0] operating_mode_field = 2'h0;
  logic termination_select = 1'h0, pos_line_pulldown_request = 1'h0;
  logic neg_line_pulldown_request = 1'h0, pll_lock = 1'h0;
  logic [BOOST_W-1:0] boost_field = 3'h0, tx_amplitude;
  logic tx_bit = 1'h0, tx_valid = 1'h0, hs_rx_bit = 1'h0, squelch = 1'h0;
  logic interface_clock_output_in, input_clock_mode = 1'h1;
  logic pos_line_pullup_enable, neg_line_pullup_enable;
  logic pos_line_pulldown_enable, neg_line_pulldown_enable;
  logic highspeed_termination_enable, output_clock_mode, dir;
  logic interface_clock_output, interface_clock_output_oe_n;
  logic tx_line, rx_data, rx_data_valid;
  int err_total = 0, checks = 0;
  wire logic [4:0] en = {pos_line_pullup_enable, neg_line_pullup_enable,
    pos_line_pulldown_enable, neg_line_pulldown_enable,
    highspeed_termination_enable};
  // Control bits in [11:5], expected enables in [4:0], undefined rows last.
  logic [11:0] rows [25] = '{12'hEE0, 12'h466, 12'h167, 12'h067, 12'hE66,
    12'h666, 12'h766, 12'hA66, 12'hB66, 12'h310, 12'h001, 12'h610, 12'h710,
    12'hA08, 12'hB08, 12'h101, 12'h332, 12'h023, 12'h632, 12'h732, 12'h123,
    12'hC00, 12'h180, 12'h400, 12'hA40};

  term_clock_ctrl #(.LOCK_CYCLES(LOCK)) u_term_clock_ctrl (.*);
  link_model u_link_model (.input_clock_mode, .interface_clock_output,
    .interface_clock_output_oe_n, .pin_level(interface_clock_output_in),
    .reference_frequency_strap(), .automatic_resume_bit());

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  // Counts a comparison and reports a mismatch.
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Holds reset for six cycles with the given strap on the clock pin.
  task automatic do_reset(logic in_mode);
    input_clock_mode = in_mode;
    pll_lock = 1'h0;
    rst_n = 1'h0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
  endtask : do_reset

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Walks every signalling row back to back, one row per cycle.
  task automatic t_table();
    foreach (rows[i]) begin
      {transceiver_speed_select, termination_select, operating_mode_field,
        pos_line_pulldown_request, neg_line_pulldown_request} = rows[i][11:5];
      @(posedge clk);
      #1;
      check("enables", {3'h0, rows[i][4:0]}, {3'h0, en});
    end
    $display("table test done");
  endtask : t_table

  // Sends nine ones and a zero, then gates the receiver by squelch.
  task automatic t_datapath();
    int n;
    logic prev;
    prev = tx_line;
    n = 0;
    tx_valid = 1'h1;
    tx_bit = 1'h1;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      #1;
      n += int'(tx_line !== prev);
      prev = tx_line;
      if (i == 8) begin
        tx_bit = 1'h0;
      end
      if (i == 9) begin
        tx_valid = 1'h0;
      end
    end
    check("line edges", 8'h2, 8'(n));
    hs_rx_bit = 1'h1;
    squelch = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    check("rx valid in squelch", 8'h0, {7'h0, rx_data_valid});
    check("rx data in squelch", 8'h0, {7'h0, rx_data});
    squelch = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    check("rx valid", 8'h1, {7'h0, rx_data_valid});
    check("rx data", 8'h1, {7'h0, rx_data});
    squelch = 1'h1;
    $display("data path test done");
  endtask : t_datapath

  // Starts up in one clock mode, then loses lock and regains it.
  task automatic t_start(logic in_mode);
    int n;
    logic prev;
    do_reset(in_mode);
    repeat (40) @(posedge clk);
    #1;
    check("dir before lock", 8'h1, {7'h0, dir});
    pll_lock = 1'h1;
    n = 0;
    while (dir !== 1'h0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("dir after lock", 8'h0, {7'h0, dir});
    check("clock mode", {7'h0, !in_mode}, {7'h0, output_clock_mode});
    check("oe_n", {7'h0, in_mode}, {7'h0, interface_clock_output_oe_n});
    n = 0;
    prev = interface_clock_output;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      n += int'(interface_clock_output !== prev);
      prev = interface_clock_output;
    end
    check("clock edges", in_mode ? 8'h0 : 8'h4, 8'(n));
    boost_field = in_mode ? 3'h5 : 3'h2;
    @(posedge clk);
    #1;
    check("boost", in_mode ? 8'h5 : 8'h2, {5'h0, tx_amplitude});
    pll_lock = 1'h0;
    repeat (6) @(posedge clk);
    #1;
    check("dir after lock loss", 8'h1, {7'h0, dir});
    pll_lock = 1'h1;
    n = 0;
    while (dir !== 1'h0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("dir after relock", 8'h0, {7'h0, dir});
    $display("start-up test done, input mode %0d", in_mode);
  endtask : t_start

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #20000;
    err_total++;
    stop_test();
  end

  // Main sequence.
  initial begin
    t_start(1'h1);
    t_table();
    t_datapath();
    t_start(1'h0);
    stop_test();
  end
endmodule : testbench
